// [logic/pms_top.sv]
// pll mode sequencer: init from nvm, modes, holdover history, ramp exit, dco steps
//
// The Avalon-MM slave port and the placing of the registers were decided locally.
`timescale 1ns/10ps
module pms_top import pms_pkg::*; #(
	parameter int unsigned SAMPLE_CYC = SAMPLE_CYCLES,
	parameter int unsigned RAMP_CYC = RAMP_TICK_CYCLES,
	parameter logic [FW-1:0] NOMINAL_WORD = 32'h00000000
) (
	input wire logic REF_CLK_I, // 100 mhz clock
	input wire logic NRST_I, // synchronous reset, active low
	input wire logic HARD_RESET_PIN_N_I, // hard reset pin, active low
	input wire logic FREQ_STEP_UP_I, // dco increment pin
	input wire logic FREQ_STEP_DOWN_I, // dco decrement pin
	input wire logic [NUM_IN-1:0] IN_VALID_I, // per input clock valid
	input wire logic PLL_LOCK_I, // loop lock detect
	input wire logic [FW-1:0] IN_FREQ_I, // measured frequency of selected input
	output logic NVM_RD_O, // nvm read request
	output logic [2:0] NVM_ADDR_O, // nvm word address
	input wire logic NVM_ACK_I, // nvm data valid
	input wire logic [31:0] NVM_DATA_I, // nvm data word
	input wire logic [3:0] AVS_ADDRESS_I, // word address
	input wire logic AVS_READ_I, // read strobe
	input wire logic AVS_WRITE_I, // write strobe
	input wire logic [31:0] AVS_WRITEDATA_I, // write data
	input wire logic [3:0] AVS_BYTEENABLE_I, // byte lanes
	output logic [31:0] AVS_READDATA_O, // read data
	output logic AVS_WAITREQUEST_O, // stall
	output logic [1:0] MODE_O, // operating mode
	output logic [1:0] SEL_IN_O, // selected input
	output logic LOCK_LOST_INDICATOR_O, // high while not locked
	output logic OUT_CLK_EN_O, // output clocks enabled
	output logic [3:0] LOOP_BW_O, // bandwidth code in use
	output logic [FW-1:0] FREQ_WORD_O, // loop frequency word
	output logic [MS_NUM*FW-1:0] DIV_OFS_O, // per divider dco offsets
	output logic EXT_REF_MODE_O, // 1 external reference, 0 crystal
	output logic [7:0] REF_PREDIV_O // reference pre-divider
);
	// ==========================================================
	// functions
	function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[8*b +: 8] = nw[8*b +: 8];
			end
		end
		return r;
	endfunction : be_merge

	function automatic logic [6:0] hist_back(input logic [6:0] ptr, input logic [7:0] back);
		int v;
		v = int'(ptr) - int'(back);
		if (v < 0) begin
			v = v + int'(HIST_DEPTH);
		end
		return 7'(v);
	endfunction : hist_back

	function automatic logic [31:0] ramp_step(input logic [5:0] idx);
		logic [31:0] s;
		logic [5:0] i;
		i = (idx > RAMP_SET_MAX) ? RAMP_SET_MAX : idx;
		s = (32'h00000002 + {31'h0, i[0]}) << i[5:1];
		return (s > RAMP_STEP_MAX) ? RAMP_STEP_MAX : s;
	endfunction : ramp_step

	// ==========================================================
	// reset and init
	logic hrst_q;
	logic rst;
	logic init_done_q;
	logic [3:0] ld_idx_q;
	logic [31:0] pend_q [CFG_WORDS];
	logic [31:0] act_q [CFG_WORDS];
	logic [31:0] step_word_q;
	logic [MS_NUM-1:0] step_mask_q;
	logic acc;
	logic bus_wr;
	logic soft_q;
	pms_ctrl_t ctl;

	assign rst = !NRST_I || hrst_q;
	assign ctl = pms_ctrl_t'(act_q[0][7:0]);
	assign acc = (AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O && init_done_q;
	assign bus_wr = AVS_WRITE_I && !AVS_WAITREQUEST_O;

	// hard reset from pin or command bit restarts everything, incl. the bus
	always_ff @(posedge REF_CLK_I) begin
		if (!NRST_I) begin
			hrst_q <= 1'b0;
		end else begin
			hrst_q <= !HARD_RESET_PIN_N_I ||
				(bus_wr && AVS_ADDRESS_I == REG_CMD && AVS_BYTEENABLE_I[0] &&
				AVS_WRITEDATA_I[CMD_HARD]);
		end
	end

	// nvm download, one word per ack
	always_ff @(posedge REF_CLK_I) begin
		if (rst) begin
			ld_idx_q <= 4'h0;
			init_done_q <= 1'b0;
			NVM_RD_O <= 1'b0;
			NVM_ADDR_O <= 3'h0;
		end else if (!init_done_q) begin
			NVM_RD_O <= !(NVM_ACK_I && ld_idx_q == 4'(CFG_WORDS - 1));
			NVM_ADDR_O <= ld_idx_q[2:0];
			if (NVM_ACK_I && NVM_RD_O) begin
				ld_idx_q <= ld_idx_q + 4'h1;
				NVM_ADDR_O <= 3'(ld_idx_q + 4'h1);
				init_done_q <= ld_idx_q == 4'(CFG_WORDS - 1);
			end
		end
	end

	// pending words take bus writes; active words change only during the nvm download or at soft reset
	always_ff @(posedge REF_CLK_I) begin
		if (rst) begin
			for (int i = 0; i < CFG_WORDS; i++) begin
				pend_q[i] <= 32'h00000000;
				act_q[i] <= 32'h00000000;
			end
			soft_q <= 1'b0;
		end else begin
			soft_q <= bus_wr && AVS_ADDRESS_I == REG_CMD && AVS_BYTEENABLE_I[0] &&
				AVS_WRITEDATA_I[CMD_SOFT];
			if (!init_done_q && NVM_ACK_I && NVM_RD_O) begin
				pend_q[ld_idx_q[2:0]] <= NVM_DATA_I;
				act_q[ld_idx_q[2:0]] <= NVM_DATA_I;
			end else if (bus_wr && AVS_ADDRESS_I < 4'(CFG_WORDS)) begin
				pend_q[AVS_ADDRESS_I[2:0]] <= be_merge(pend_q[AVS_ADDRESS_I[2:0]],
					AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
			end
			if (soft_q) begin
				for (int i = 0; i < CFG_WORDS; i++) begin
					act_q[i] <= pend_q[i];
				end
			end
		end
	end

	always_ff @(posedge REF_CLK_I) begin
		if (rst) begin
			step_word_q <= STEP_WORD_RST;
			step_mask_q <= STEP_MASK_RST;
		end else if (bus_wr && AVS_ADDRESS_I == REG_STEP_WORD) begin
			step_word_q <= be_merge(step_word_q, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
		end else if (bus_wr && AVS_ADDRESS_I == REG_STEP_MASK && AVS_BYTEENABLE_I[0]) begin
			step_mask_q <= AVS_WRITEDATA_I[MS_NUM-1:0];
		end
	end

	// ==========================================================
	// input selection and mode machine
	pms_mode_t mode_q;
	logic [1:0] sel_q;
	logic from_hold_q;
	logic sel_ok;
	logic any_ok;
	logic [1:0] best;
	logic [6:0] hist_cnt_q;
	logic avg_go;

	always_comb begin
		best = 2'h0;
		for (int i = NUM_IN - 1; i >= 0; i--) begin
			if (IN_VALID_I[i]) begin
				best = 2'(i);
			end
		end
		any_ok = ctl.auto_sel ? |IN_VALID_I : IN_VALID_I[ctl.manual_sel];
		sel_ok = IN_VALID_I[sel_q];
	end

	assign avg_go = init_done_q && !sel_ok && !any_ok && hist_cnt_q != 7'h00 &&
		(mode_q == MODE_LOCKED || mode_q == MODE_ACQ);

	always_ff @(posedge REF_CLK_I) begin
		if (rst || !init_done_q) begin
			mode_q <= MODE_FREERUN;
			sel_q <= 2'h0;
			from_hold_q <= 1'b0;
		end else begin
			if (any_ok) begin
				sel_q <= ctl.auto_sel ? (sel_ok ? sel_q : best) : ctl.manual_sel;
			end
			unique case (mode_q)
				MODE_FREERUN: begin
					if (any_ok) begin
						mode_q <= MODE_ACQ;
					end
				end
				MODE_ACQ, MODE_LOCKED: begin
					if (!sel_ok && !any_ok) begin
						mode_q <= avg_go ? MODE_HOLDOVER : MODE_FREERUN;
					end else if (!sel_ok) begin
						mode_q <= MODE_ACQ;
					end else if (PLL_LOCK_I) begin
						mode_q <= MODE_LOCKED;
						from_hold_q <= 1'b0;
					end else begin
						mode_q <= MODE_ACQ;
					end
				end
				MODE_HOLDOVER: begin
					if (any_ok) begin
						mode_q <= MODE_ACQ;
						from_hold_q <= 1'b1;
					end
				end
			endcase
		end
	end

	// ==========================================================
	// frequency history while locked
	logic [FW-1:0] hist_q [HIST_DEPTH];
	logic [6:0] wr_ptr_q;
	logic [31:0] smp_cnt_q;

	always_ff @(posedge REF_CLK_I) begin
		if (rst) begin
			wr_ptr_q <= 7'h00;
			hist_cnt_q <= 7'h00;
			smp_cnt_q <= 32'h00000000;
			for (int i = 0; i < HIST_DEPTH; i++) begin
				hist_q[i] <= '0;
			end
		end else if (mode_q == MODE_LOCKED) begin
			smp_cnt_q <= smp_cnt_q + 32'h1;
			if (smp_cnt_q == 32'(SAMPLE_CYC - 1)) begin
				smp_cnt_q <= 32'h00000000;
				hist_q[wr_ptr_q] <= IN_FREQ_I;
				wr_ptr_q <= (wr_ptr_q == 7'(HIST_DEPTH - 1)) ? 7'h00 : wr_ptr_q + 7'h1;
				if (hist_cnt_q != 7'(HIST_DEPTH)) begin
					hist_cnt_q <= hist_cnt_q + 7'h1;
				end
			end
		end else begin
			smp_cnt_q <= 32'h00000000;
		end
	end

	// ==========================================================
	// holdover averaging: sum 2^win samples starting dly back from newest
	logic avg_busy_q;
	logic [6:0] avg_left_q;
	logic [7:0] avg_back_q;
	logic [FW+6:0] avg_sum_q;
	logic [2:0] win_q;
	logic [FW-1:0] hold_q;
	logic [2:0] win_cfg;
	logic [7:0] need;

	assign win_cfg = (act_q[REG_HOLD_WIN[2:0]][2:0] > HOLD_WIN_MAX) ? HOLD_WIN_MAX :
		act_q[REG_HOLD_WIN[2:0]][2:0];
	assign need = act_q[REG_HOLD_DLY[2:0]][7:0] + (8'h01 << win_cfg);

	always_ff @(posedge REF_CLK_I) begin
		if (rst) begin
			avg_busy_q <= 1'b0;
			avg_left_q <= 7'h00;
			avg_back_q <= 8'h00;
			avg_sum_q <= '0;
			win_q <= 3'h0;
			hold_q <= NOMINAL_WORD;
		end else if (avg_go) begin
			avg_busy_q <= 1'b1;
			avg_sum_q <= '0;
			// too little history: fall back to the newest sample alone
			win_q <= (need <= {1'b0, hist_cnt_q}) ? win_cfg : 3'h0;
			avg_left_q <= (need <= {1'b0, hist_cnt_q}) ? (7'h01 << win_cfg) : 7'h01;
			avg_back_q <= (need <= {1'b0, hist_cnt_q}) ?
				act_q[REG_HOLD_DLY[2:0]][7:0] + 8'h01 : 8'h01;
		end else if (avg_busy_q) begin
			if (avg_left_q == 7'h00) begin
				avg_busy_q <= 1'b0;
				hold_q <= FW'(avg_sum_q >> win_q);
			end else begin
				avg_sum_q <= avg_sum_q + (FW+7)'(hist_q[hist_back(wr_ptr_q, avg_back_q)]);
				avg_back_q <= avg_back_q + 8'h01;
				avg_left_q <= avg_left_q - 7'h01;
			end
		end
	end

	// ==========================================================
	// ramped slew toward the input, shared by holdover exit and input switch
	logic ramp_q;
	logic [FW-1:0] ramp_word_q;
	logic [31:0] tick_q;
	logic [31:0] rstep;
	logic [1:0] prev_sel_q;
	logic ramp_start;

	assign rstep = ramp_step(act_q[REG_RAMP_RATE[2:0]][5:0]);
	assign ramp_start = ctl.ramp_exit_en && mode_q != MODE_FREERUN &&
		((mode_q == MODE_HOLDOVER && any_ok) || (prev_sel_q != sel_q));

	always_ff @(posedge REF_CLK_I) begin
		if (rst) begin
			ramp_q <= 1'b0;
			ramp_word_q <= NOMINAL_WORD;
			tick_q <= 32'h00000000;
			prev_sel_q <= 2'h0;
		end else begin
			prev_sel_q <= sel_q;
			if (ramp_start) begin
				ramp_q <= 1'b1;
				tick_q <= 32'h00000000;
				ramp_word_q <= FREQ_WORD_O; // start from the word in use
			end else if (ramp_q) begin
				tick_q <= (tick_q == 32'(RAMP_CYC - 1)) ? 32'h00000000 : tick_q + 32'h1;
				if (tick_q == 32'(RAMP_CYC - 1)) begin
					if ($signed(IN_FREQ_I - ramp_word_q) > $signed(rstep)) begin
						ramp_word_q <= ramp_word_q + rstep;
					end else if ($signed(ramp_word_q - IN_FREQ_I) > $signed(rstep)) begin
						ramp_word_q <= ramp_word_q - rstep;
					end else begin
						ramp_word_q <= IN_FREQ_I;
						ramp_q <= 1'b0;
					end
				end
			end
		end
	end

	// ==========================================================
	// dco steps, pins edge detected
	logic up_q;
	logic dn_q;
	logic step_up;
	logic step_dn;
	logic [FW-1:0] ofs_q [MS_NUM];
	logic cmd_wr;

	assign cmd_wr = bus_wr && AVS_ADDRESS_I == REG_CMD && AVS_BYTEENABLE_I[0];
	assign step_up = (FREQ_STEP_UP_I && !up_q) || (cmd_wr && AVS_WRITEDATA_I[CMD_UP]);
	assign step_dn = (FREQ_STEP_DOWN_I && !dn_q) || (cmd_wr && AVS_WRITEDATA_I[CMD_DOWN]);

	always_ff @(posedge REF_CLK_I) begin
		if (rst) begin
			up_q <= 1'b0;
			dn_q <= 1'b0;
			for (int i = 0; i < MS_NUM; i++) begin
				ofs_q[i] <= '0;
			end
		end else begin
			up_q <= FREQ_STEP_UP_I;
			dn_q <= FREQ_STEP_DOWN_I;
			if (ctl.dco_en && (mode_q == MODE_FREERUN || mode_q == MODE_LOCKED) &&
					(step_up != step_dn)) begin
				for (int i = 0; i < MS_NUM; i++) begin
					if (step_mask_q[i]) begin
						ofs_q[i] <= step_up ? ofs_q[i] + step_word_q : ofs_q[i] - step_word_q;
					end
				end
			end
		end
	end

	// ==========================================================
	// loop outputs
	logic [3:0] fast_bw;

	assign fast_bw = (act_q[REG_FAST_BW[2:0]][3:0] < FL_BW_MIN) ? FL_BW_MIN :
		(act_q[REG_FAST_BW[2:0]][3:0] > FL_BW_MAX) ? FL_BW_MAX :
		act_q[REG_FAST_BW[2:0]][3:0];

	always_ff @(posedge REF_CLK_I) begin
		if (rst) begin
			FREQ_WORD_O <= NOMINAL_WORD;
			LOOP_BW_O <= 4'h0;
			LOCK_LOST_INDICATOR_O <= 1'b1;
			OUT_CLK_EN_O <= 1'b0;
			MODE_O <= MODE_FREERUN;
			SEL_IN_O <= 2'h0;
			EXT_REF_MODE_O <= 1'b0;
			REF_PREDIV_O <= 8'h00;
			DIV_OFS_O <= '0;
		end else begin
			OUT_CLK_EN_O <= init_done_q;
			MODE_O <= mode_q;
			SEL_IN_O <= sel_q;
			LOCK_LOST_INDICATOR_O <= mode_q != MODE_LOCKED;
			EXT_REF_MODE_O <= ctl.ext_ref_mode;
			REF_PREDIV_O <= act_q[REG_PREDIV[2:0]][7:0];
			for (int i = 0; i < MS_NUM; i++) begin
				DIV_OFS_O[i*FW +: FW] <= ofs_q[i];
			end
			unique case (mode_q)
				MODE_FREERUN: FREQ_WORD_O <= NOMINAL_WORD;
				MODE_HOLDOVER: FREQ_WORD_O <= hold_q;
				MODE_ACQ: FREQ_WORD_O <= ramp_q ? ramp_word_q : IN_FREQ_I;
				MODE_LOCKED: FREQ_WORD_O <= ramp_q ? ramp_word_q : IN_FREQ_I;
			endcase
			if (mode_q == MODE_ACQ && from_hold_q && !ctl.ramp_exit_en && ctl.exit_bw_sel) begin
				LOOP_BW_O <= act_q[REG_EXIT_BW[2:0]][3:0];
			end else if (mode_q == MODE_ACQ && ctl.fastlock_en && !from_hold_q) begin
				LOOP_BW_O <= fast_bw;
			end else begin
				LOOP_BW_O <= act_q[REG_LOOP_BW[2:0]][3:0];
			end
		end
	end

	// ==========================================================
	// avalon slave: one wait cycle, no answer before init
	pms_status_t st;

	assign st = '{ramping: ramp_q, averaging: avg_busy_q, hist_valid: hist_cnt_q != 7'h00,
		lock_lost: LOCK_LOST_INDICATOR_O, init_done: init_done_q, sel_in: sel_q,
		mode: mode_q};

	always_ff @(posedge REF_CLK_I) begin
		if (rst) begin
			AVS_WAITREQUEST_O <= 1'b1;
			AVS_READDATA_O <= 32'h00000000;
		end else begin
			AVS_WAITREQUEST_O <= !acc;
			if (acc && AVS_READ_I) begin
				if (AVS_ADDRESS_I < 4'(CFG_WORDS)) begin
					AVS_READDATA_O <= pend_q[AVS_ADDRESS_I[2:0]];
				end else if (AVS_ADDRESS_I == REG_STEP_WORD) begin
					AVS_READDATA_O <= step_word_q;
				end else if (AVS_ADDRESS_I == REG_STEP_MASK) begin
					AVS_READDATA_O <= 32'(step_mask_q);
				end else if (AVS_ADDRESS_I == REG_STATUS) begin
					AVS_READDATA_O <= 32'(st);
				end else if (AVS_ADDRESS_I == REG_FREQ) begin
					AVS_READDATA_O <= FREQ_WORD_O;
				end else if (AVS_ADDRESS_I == REG_HOLD_FREQ) begin
					AVS_READDATA_O <= hold_q;
				end else begin
					AVS_READDATA_O <= 32'h00000000;
				end
			end
		end
	end
endmodule : pms_top

// [logic/pms_pkg.sv]
// package for the pll mode sequencer: register map, fields, modes, timing
package pms_pkg;
	// ==========================================================
	// clock and timing
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned HIST_SECONDS = 120;
	localparam int unsigned SAMPLE_PERIOD_MS = 1000;
	localparam int unsigned RAMP_TICK_US = 1000;
	localparam int unsigned SAMPLE_CYCLES = CLK_HZ / 1000 * SAMPLE_PERIOD_MS;
	localparam int unsigned RAMP_TICK_CYCLES = CLK_HZ / 1_000_000 * RAMP_TICK_US;
	localparam int unsigned HIST_DEPTH = HIST_SECONDS * 1000 / SAMPLE_PERIOD_MS;

	// ==========================================================
	// frequency words, lsb is 0.0001 ppm
	localparam int unsigned FW = 32;
	localparam int unsigned MS_NUM = 5;
	localparam int unsigned NUM_IN = 4;
	localparam int unsigned CFG_WORDS = 8;
	localparam logic [31:0] RAMP_STEP_MAX = 32'h00061a80;
	localparam logic [5:0] RAMP_SET_MAX = 6'h27;
	localparam logic [3:0] FL_BW_MIN = 4'h6;
	localparam logic [3:0] FL_BW_MAX = 4'hb;
	localparam logic [2:0] HOLD_WIN_MAX = 3'h6;

	// ==========================================================
	// register word indices (byte address = index * 4)
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_LOOP_BW = 4'h1;
	localparam logic [3:0] REG_FAST_BW = 4'h2;
	localparam logic [3:0] REG_EXIT_BW = 4'h3;
	localparam logic [3:0] REG_RAMP_RATE = 4'h4;
	localparam logic [3:0] REG_HOLD_WIN = 4'h5;
	localparam logic [3:0] REG_HOLD_DLY = 4'h6;
	localparam logic [3:0] REG_PREDIV = 4'h7;
	localparam logic [3:0] REG_STEP_WORD = 4'h8;
	localparam logic [3:0] REG_STEP_MASK = 4'h9;
	localparam logic [3:0] REG_CMD = 4'ha;
	localparam logic [3:0] REG_STATUS = 4'hb;
	localparam logic [3:0] REG_FREQ = 4'hc;
	localparam logic [3:0] REG_HOLD_FREQ = 4'hd;

	// command register bits, self clearing
	localparam int unsigned CMD_SOFT = 0;
	localparam int unsigned CMD_HARD = 1;
	localparam int unsigned CMD_UP = 2;
	localparam int unsigned CMD_DOWN = 3;

	// reset values of non volatile words are whatever nvm holds
	localparam logic [31:0] STEP_WORD_RST = 32'h00000000;
	localparam logic [MS_NUM-1:0] STEP_MASK_RST = 5'h00;

	// ==========================================================
	// types
	typedef struct packed {
		logic dco_en;
		logic [1:0] manual_sel;
		logic auto_sel;
		logic ext_ref_mode;
		logic exit_bw_sel;
		logic ramp_exit_en;
		logic fastlock_en;
	} pms_ctrl_t;

	typedef enum logic [1:0] {
		MODE_FREERUN = 2'b00,
		MODE_ACQ = 2'b01,
		MODE_LOCKED = 2'b11,
		MODE_HOLDOVER = 2'b10
	} pms_mode_t;

	typedef struct packed {
		logic ramping;
		logic averaging;
		logic hist_valid;
		logic lock_lost;
		logic init_done;
		logic [1:0] sel_in;
		pms_mode_t mode;
	} pms_status_t;
endpackage : pms_pkg

// [tb/pms_nvm_model.sv]
// nvm partner model: answers word reads after a settable latency
`timescale 1ns/10ps
module pms_nvm_model #(
	parameter logic [8*32-1:0] IMAGE = '0
) (
	input wire logic clk_i, // clock
	input wire logic [3:0] lat_i, // wait cycles before each answer
	input wire logic rd_i, // word request
	input wire logic [2:0] addr_i, // word index
	output logic ack_o, // data valid
	output logic [31:0] data_o // data word
);
	logic [3:0] cnt_q;
	initial begin
		ack_o = 1'b0;
		data_o = 32'h0;
		cnt_q = 4'h0;
	end
	// ==========================================================
	// responder
	always @(posedge clk_i) begin
		if (rd_i && !ack_o && cnt_q >= lat_i) begin
			ack_o <= 1'b1;
			data_o <= IMAGE[addr_i*32 +: 32];
			cnt_q <= 4'h0;
		end else begin
			ack_o <= 1'b0;
			// data toggles outside a reply so a late sample never looks right
			data_o <= ~data_o;
			cnt_q <= (rd_i && !ack_o) ? cnt_q + 4'h1 : 4'h0;
		end
	end
endmodule : pms_nvm_model

// [tb/pms_top_monitor.sv]
// port checker of the pll mode sequencer
`timescale 1ns/10ps
module pms_top_monitor import pms_pkg::*; (
	input wire logic REF_CLK_I, // clock
	input wire logic NRST_I, // sync reset
	input wire logic HARD_RESET_PIN_N_I, // hard reset pin
	input wire logic FREQ_STEP_UP_I, // step up pin
	input wire logic FREQ_STEP_DOWN_I, // step down pin
	input wire logic AVS_WRITE_I, // bus write
	input wire logic NVM_RD_O, // nvm request
	input wire logic [2:0] NVM_ADDR_O, // nvm word
	input wire logic NVM_ACK_I, // nvm answer
	input wire logic AVS_WAITREQUEST_O, // bus stall
	input wire logic [1:0] MODE_O, // mode
	input wire logic LOCK_LOST_INDICATOR_O, // loss of lock
	input wire logic OUT_CLK_EN_O, // clocks on
	input wire logic [MS_NUM*FW-1:0] DIV_OFS_O // dco offsets
);
	default clocking @(posedge REF_CLK_I); endclocking
	default disable iff (!NRST_I);
	logic up_q, dn_q;
	logic [3:0] calm_q;
	// calm: no pin edge, no bus write, no reset for four cycles
	always_ff @(posedge REF_CLK_I) begin
		up_q <= FREQ_STEP_UP_I;
		dn_q <= FREQ_STEP_DOWN_I;
		calm_q <= {calm_q[2:0], up_q == FREQ_STEP_UP_I && dn_q == FREQ_STEP_DOWN_I
			&& !AVS_WRITE_I && HARD_RESET_PIN_N_I && NRST_I};
	end
	// ==========================================================
	// assertions
	a_reset_state: assert property (disable iff (1'b0) !NRST_I [*2] |=>
		MODE_O == MODE_FREERUN && !OUT_CLK_EN_O && AVS_WAITREQUEST_O && !NVM_RD_O)
		else $error("reset state wrong");
	a_nvm_first: assert property ($rose(NVM_RD_O) |-> NVM_ADDR_O == 3'h0 && !OUT_CLK_EN_O)
		else $error("nvm load not from word 0");
	a_nvm_order: assert property (NVM_RD_O && NVM_ACK_I && NVM_ADDR_O != 3'h7 |=>
		NVM_RD_O && NVM_ADDR_O == $past(NVM_ADDR_O) + 3'h1) else $error("nvm order wrong");
	a_nvm_done: assert property (NVM_RD_O && NVM_ACK_I && NVM_ADDR_O == 3'h7 |=>
		!NVM_RD_O ##1 OUT_CLK_EN_O) else $error("init not done after last word");
	a_bus_after_init: assert property (!AVS_WAITREQUEST_O |-> ##[0:1] OUT_CLK_EN_O)
		else $error("bus answered during init");
	a_init_freerun: assert property ($rose(OUT_CLK_EN_O) |-> MODE_O == MODE_FREERUN)
		else $error("not free-run after init");
	a_lol_mode: assert property (LOCK_LOST_INDICATOR_O == (MODE_O != MODE_LOCKED))
		else $error("loss of lock pin wrong");
	a_step_quiet: assert property (&calm_q |-> $stable(DIV_OFS_O))
		else $error("offset moved without request");
	c_hold: cover property (MODE_O == MODE_HOLDOVER);
	c_lock: cover property (MODE_O == MODE_LOCKED);
	c_step: cover property ($changed(DIV_OFS_O));
endmodule : pms_top_monitor

bind pms_top pms_top_monitor u_mon (.REF_CLK_I, .NRST_I, .HARD_RESET_PIN_N_I, .FREQ_STEP_UP_I,
	.FREQ_STEP_DOWN_I, .AVS_WRITE_I, .NVM_RD_O, .NVM_ADDR_O, .NVM_ACK_I, .AVS_WAITREQUEST_O,
	.MODE_O, .LOCK_LOST_INDICATOR_O, .OUT_CLK_EN_O, .DIV_OFS_O);

// [tb/pms_top_test.sv]
// self-checking bench of the pll mode sequencer
`timescale 1ns/10ps
module pms_top_test import pms_pkg::*;;
	// words 0..7: ctrl, loop bw, fast bw, exit bw, ramp, window, delay, prediv
	localparam logic [8*32-1:0] IMAGE = {32'h2, 32'h0, 32'h1, 32'h2, 32'h5, 32'h8, 32'h3, 32'h91};
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic hard_n = 1'b1;
	logic up = 1'b0;
	logic dn = 1'b0;
	logic pll_lock = 1'b0;
	logic [3:0] in_valid = 4'h0;
	logic [3:0] lat = 4'h1;
	logic [31:0] in_freq = 32'h1234;
	logic [3:0] addr = 4'h0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic nvm_rd, nvm_ack, waitreq, lock_lost_indicator, clk_en, ext_ref;
	logic [2:0] nvm_addr;
	logic [31:0] nvm_data, rdata, fword, q;
	logic [1:0] mode, sel;
	logic [3:0] bw;
	logic [7:0] prediv;
	logic [159:0] ofs;
	int err_total = 0;
	int n_compared = 0;
	always #5 clk = ~clk;
	pms_top #(.SAMPLE_CYC(20), .RAMP_CYC(4)) dut (.REF_CLK_I(clk), .NRST_I(nrst),
		.HARD_RESET_PIN_N_I(hard_n), .FREQ_STEP_UP_I(up), .FREQ_STEP_DOWN_I(dn),
		.IN_VALID_I(in_valid), .PLL_LOCK_I(pll_lock), .IN_FREQ_I(in_freq), .NVM_RD_O(nvm_rd),
		.NVM_ADDR_O(nvm_addr), .NVM_ACK_I(nvm_ack), .NVM_DATA_I(nvm_data), .AVS_ADDRESS_I(addr),
		.AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(4'hf),
		.AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(waitreq), .MODE_O(mode), .SEL_IN_O(sel),
		.LOCK_LOST_INDICATOR_O(lock_lost_indicator), .OUT_CLK_EN_O(clk_en), .LOOP_BW_O(bw), .FREQ_WORD_O(fword),
		.DIV_OFS_O(ofs), .EXT_REF_MODE_O(ext_ref), .REF_PREDIV_O(prediv));
	pms_nvm_model #(.IMAGE(IMAGE)) u_nvm (.clk_i(clk), .lat_i(lat), .rd_i(nvm_rd),
		.addr_i(nvm_addr), .ack_o(nvm_ack), .data_o(nvm_data));
	// ==========================================================
	// tasks
	task automatic wrap_up;
		$display("compared %0d, errors %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : wrap_up
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// request stands until waitrequest is seen low at a rising edge; only the watchdog ends a hang
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		addr <= a;
		wdata <= d;
		wr <= w;
		rd <= !w;
		do begin
			@(posedge clk);
		end while (waitreq !== 1'b0);
		q = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
		@(posedge clk);
	endtask : bus
	task automatic wait_mode(input pms_mode_t m);
		int n;
		n = 0;
		while (mode !== m && n < 300) begin
			@(negedge clk);
			n++;
		end
		chk(32'(mode), 32'(m));
		@(posedge clk);
	endtask : wait_mode
	task automatic pulse(input logic u, input logic d);
		up <= u;
		dn <= d;
		repeat (4) @(posedge clk);
		up <= 1'b0;
		dn <= 1'b0;
		repeat (4) @(posedge clk);
	endtask : pulse
	// ==========================================================
	// tests
	initial begin
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		bus(0, REG_CTRL, 0);
		chk(q, 32'h91);
		chk(32'(clk_en), 32'h1);
		chk(32'(mode), 32'(MODE_FREERUN));
		bus(0, REG_STATUS, 0);
		chk(32'(q[5:4]), 32'h3);
		bus(0, 4'he, 0);
		chk(q, 32'h0);
		bus(1, REG_STEP_WORD, 32'h10);
		bus(1, REG_STEP_MASK, 32'h3);
		pulse(1, 0);
		chk(ofs[63:32], 32'h10);
		chk(ofs[95:64], 32'h0);
		pulse(0, 1);
		chk(ofs[31:0], 32'h0);
		pulse(1, 1);
		chk(ofs[31:0], 32'h0);
		bus(1, REG_CMD, 32'h4);
		repeat (2) @(posedge clk);
		chk(ofs[31:0], 32'h10);
		bus(1, REG_CMD, 32'h8);
		repeat (2) @(posedge clk);
		chk(ofs[31:0], 32'h0);
		in_valid <= 4'b0010;
		wait_mode(MODE_ACQ);
		chk(32'(bw), 32'h8);
		chk(32'(sel), 32'h1);
		pll_lock <= 1'b1;
		wait_mode(MODE_LOCKED);
		repeat (3) @(posedge clk);
		chk(32'(bw), 32'h3);
		chk(32'(lock_lost_indicator), 32'h0);
		chk(fword, 32'h1234);
		pulse(1, 0);
		chk(ofs[31:0], 32'h10);
		repeat (300) @(posedge clk);
		in_valid <= 4'h0;
		pll_lock <= 1'b0;
		wait_mode(MODE_HOLDOVER);
		// input word moves away, holdover must keep the averaged history
		in_freq <= 32'h2000;
		repeat (50) @(posedge clk);
		chk(fword, 32'h1234);
		pulse(1, 0);
		chk(ofs[31:0], 32'h10);
		in_valid <= 4'b0100;
		wait_mode(MODE_ACQ);
		// exit without ramp and without exit bandwidth runs on the loop bandwidth
		chk(32'(bw), 32'h3);
		bus(1, REG_CTRL, 32'h9d);
		bus(1, REG_PREDIV, 32'h5);
		bus(0, REG_CTRL, 0);
		chk(q, 32'h9d);
		chk(32'(ext_ref), 32'h0);
		bus(1, REG_CMD, 32'h1);
		repeat (3) @(posedge clk);
		chk(32'(ext_ref), 32'h1);
		chk(32'(prediv), 32'h5);
		pll_lock <= 1'b1;
		wait_mode(MODE_LOCKED);
		repeat (300) @(posedge clk);
		in_valid <= 4'h0;
		pll_lock <= 1'b0;
		wait_mode(MODE_HOLDOVER);
		in_valid <= 4'b0001;
		wait_mode(MODE_ACQ);
		repeat (2) @(posedge clk);
		chk(32'(bw), 32'h5);
		// ramped exit: rate code 2 gives 4 lsb every 4 cycles
		bus(1, REG_CTRL, 32'h9f);
		bus(1, REG_CMD, 32'h1);
		pll_lock <= 1'b1;
		wait_mode(MODE_LOCKED);
		repeat (60) @(posedge clk);
		in_valid <= 4'h0;
		pll_lock <= 1'b0;
		wait_mode(MODE_HOLDOVER);
		in_freq <= 32'h2040;
		in_valid <= 4'b0001;
		wait_mode(MODE_ACQ);
		repeat (8) @(posedge clk);
		chk(fword, 32'h2008);
		repeat (80) @(posedge clk);
		chk(fword, 32'h2040);
		in_valid <= 4'h0;
		lat <= 4'h6;
		hard_n <= 1'b0;
		repeat (2) @(posedge clk);
		hard_n <= 1'b1;
		@(posedge clk);
		bus(0, REG_CTRL, 0);
		chk(q, 32'h91);
		chk(32'(ext_ref), 32'h0);
		chk(32'(prediv), 32'h2);
		chk(ofs[31:0], 32'h0);
		bus(1, REG_CTRL, 32'h99);
		bus(1, REG_CMD, 32'h2);
		repeat (3) @(posedge clk);
		bus(0, REG_CTRL, 0);
		chk(q, 32'h91);
		chk(32'(mode), 32'(MODE_FREERUN));
		wrap_up();
	end
	initial begin
		repeat (30000) @(posedge clk);
		err_total++;
		wrap_up();
	end
endmodule : pms_top_test
